// file: core/fcs_pkg.sv
package fcs_pkg;
  // ----------------------------------------
  // Unlock offsets and command bytes
  // ----------------------------------------
  localparam logic [15:0] UNLOCK_ADDR_A  = 16'h5555;
  localparam logic [15:0] UNLOCK_ADDR_B  = 16'h2aaa;
  localparam logic [7:0]  UNLOCK_DATA_A  = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA_B  = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_PRE  = 8'h80;
  localparam logic [7:0]  CMD_SECTOR_ERS = 8'h30;
  localparam logic [7:0]  CMD_BLOCK_ERS  = 8'h50;
  localparam logic [7:0]  CMD_CHIP_ERS   = 8'h10;
  localparam logic [7:0]  CMD_ID_ENTRY   = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT    = 8'hf0;

  // ----------------------------------------
  // Identification codes (arbitrary values)
  // ----------------------------------------
  localparam logic [7:0]  MAKER_CODE     = 8'h3c;
  localparam logic [7:0]  PART_CODE      = 8'h7e;

  // ----------------------------------------
  // Timing, in ns, and the clock period
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int PROG_MAX_NS     = 20000;
  localparam int ERASE_MAX_NS    = 25000000;
  localparam int RESET_ABORT_NS  = 10000;
  // Longest times round down to whole cycles
  localparam int PROG_CYCLES     = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES    = ERASE_MAX_NS / CLK_PERIOD_NS;
  localparam int ABORT_CYCLES    = RESET_ABORT_NS / CLK_PERIOD_NS;
  localparam int ADDR_W          = 19;
  localparam int CNT_W           = 24;

  // ----------------------------------------
  // Internal operation kinds
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE   = 4'b0001,
    OP_PROG   = 4'b0010,
    OP_ERASE  = 4'b0100,
    OP_CHIP   = 4'b1000
  } fcs_op_e;
endpackage : fcs_pkg

// file: core/fcs_op_timer.sv
`timescale 1ns/10ps
// Duration counter for one internal program or erase
module fcs_op_timer
  import fcs_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Control
  input  wire logic          start,
  input  wire logic          abort,
  input  wire logic [CW-1:0] limit,
  // Status
  output logic               busy,
  output logic               done
);
  logic [CW-1:0] count_reg;   // Elapsed cycles

  // Counter cleared on start and on abort
  always_ff @(posedge clk)
  begin
    if (reset || abort || start)
      count_reg <= '0;
    else if (busy)
      count_reg <= count_reg + 1'b1;
  end

  // Busy flag; done pulses at the limit
  always_ff @(posedge clk)
  begin
    if (reset || abort)
      busy <= 1'b0;
    else if (start)
      busy <= 1'b1;
    else if (busy && count_reg == limit - 1'b1)
      busy <= 1'b0;
  end

  assign done = busy && !start && (count_reg == limit - 1'b1);
endmodule : fcs_op_timer

// file: core/fcs_sequencer.sv
`timescale 1ns/10ps
// What this block does
// - Three unlock writes then program byte
// - Five unlock writes, then 30H sector erase
// - Five unlock writes, then 50H block erase
// - Five unlock writes, then 10H at 5555H
// - Whole-array erase only in parallel mode
// - AAH 55H 90H enters identification mode
// - F0H alone or unlocked exits identification
// - Bit 0 selects maker or part code
// - OE high, WE rising captures command cycle
// - Reset low floats data pins
// - No write with WE high or OE low
// - Erase takes address; chip erase ignores it
// - Reset aborts operation within 10 us
// - Program finishes within 20 us
// - Sector or block erase within 25 ms
// - Idle ready in idle state with timer stopped
// - Bad write mid-sequence returns to read
// - Busy reads: inverted bit 7, bit 6 toggles
// - Commands ignored during erase
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int PROG_LIMIT  = PROG_CYCLES,
  parameter int ERASE_LIMIT = ERASE_CYCLES,
  parameter int CHIP_LIMIT  = ERASE_CYCLES
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Mode strap and pins (asynchronous)
  input  wire logic              parallel_prog_mode,
  input  wire logic              rstPinN,
  input  wire logic              outEnN,
  input  wire logic              writeEnN,
  input  wire logic [31:0]       addrIn,
  input  wire logic [7:0]        dataIn,
  // Array read data for addressed byte
  input  wire logic [7:0]        arrayData,
  // Data pin drive
  output logic [7:0]             dataOut,
  output logic                   dataOe,
  // Internal operation requests and status
  output logic                   progStart,
  output logic                   eraseStart,
  output logic                   chipErase,
  output logic [ADDR_W-1:0]      target_byte_addr,
  output logic [ADDR_W-1:0]      sector_sel_addr,
  output logic [7:0]             progData,
  output logic                   opBusy,
  output logic                   idMode,
  output logic                   readyIdle
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0]  metaCtl_reg, syncCtl_reg; // Mode, reset, OE, WE
  logic [31:0] metaAddr_reg, syncAddr_reg;
  logic [7:0]  metaData_reg, syncData_reg;
  logic        weLast_reg;               // WE level one cycle back

  // Two-flop capture of every pin
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // Idle levels: strobes high, pin reset released, no false WE edge
      metaCtl_reg <= 4'h7;
      syncCtl_reg <= 4'h7;
      metaAddr_reg <= '0;
      syncAddr_reg <= '0;
      metaData_reg <= '0;
      syncData_reg <= '0;
    end
    else
    begin
      metaCtl_reg <= {parallel_prog_mode, rstPinN, outEnN, writeEnN};
      syncCtl_reg <= metaCtl_reg;
      metaAddr_reg <= addrIn;
      syncAddr_reg <= metaAddr_reg;
      metaData_reg <= dataIn;
      syncData_reg <= metaData_reg;
    end
  end

  logic ppMode, rstN, oeN, weN;
  assign {ppMode, rstN, oeN, weN} = syncCtl_reg;

  // WE history for the rising edge
  always_ff @(posedge clk)
  begin
    if (reset)
      weLast_reg <= 1'b1;
    else
      weLast_reg <= weN;
  end

  // Command cycle ends on WE rising with OE high
  logic cmdWrite;
  assign cmdWrite = rstN && oeN && weLast_reg == 1'b0
                    && weN;
  logic readCycle;
  assign readCycle = rstN && !oeN && weN;

  // Address match helper
  function automatic logic atOff(input logic [31:0] a,
                                 input logic [15:0] off);
    atOff = (a[15:0] == off);
  endfunction : atOff

  // ----------------------------------------
  // Command decoder
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'b000000001,
    ST_U1    = 9'b000000010,
    ST_U2    = 9'b000000100,
    ST_PADDR = 9'b000001000,
    ST_E1    = 9'b000010000,
    ST_E2    = 9'b000100000,
    ST_E3    = 9'b001000000,
    ST_BUSY  = 9'b010000000,
    ST_ABORT = 9'b100000000
  } fcs_state_e;

  fcs_state_e state_reg, state_next;
  fcs_op_e    op_reg;
  logic [7:0] wd;
  logic [31:0] wa;
  logic       opDone;
  logic       startProg, startErase, startChip;
  logic       idEnter, idExit;
  logic [CNT_W-1:0] abortCnt_reg;

  assign wd = syncData_reg;
  assign wa = syncAddr_reg;

  // Next-state decode of each command cycle
  always_comb
  begin
    state_next = state_reg;
    startProg = 1'b0;
    startErase = 1'b0;
    startChip = 1'b0;
    idEnter = 1'b0;
    idExit = 1'b0;
    case (state_reg)
      ST_IDLE:
        if (cmdWrite)
        begin
          if (wd == CMD_ID_EXIT)
            idExit = 1'b1;
          else if (wd == UNLOCK_DATA_A && atOff(wa, UNLOCK_ADDR_A))
            state_next = ST_U1;
        end
      ST_U1:
        if (cmdWrite)
          state_next = (wd == UNLOCK_DATA_B && atOff(wa, UNLOCK_ADDR_B))
                       ? ST_U2 : ST_IDLE;
      ST_U2:
        if (cmdWrite)
        begin
          state_next = ST_IDLE;
          if (atOff(wa, UNLOCK_ADDR_A))
          begin
            if (wd == CMD_PROGRAM)
              state_next = ST_PADDR;
            else if (wd == CMD_ERASE_PRE)
              state_next = ST_E1;
            else if (wd == CMD_ID_ENTRY)
              idEnter = 1'b1;
            else if (wd == CMD_ID_EXIT)
              idExit = 1'b1;
          end
        end
      ST_PADDR:
        if (cmdWrite)
        begin
          startProg = 1'b1;
          state_next = ST_BUSY;
        end
      ST_E1:
        if (cmdWrite)
          state_next = (wd == UNLOCK_DATA_A && atOff(wa, UNLOCK_ADDR_A))
                       ? ST_E2 : ST_IDLE;
      ST_E2:
        if (cmdWrite)
          state_next = (wd == UNLOCK_DATA_B && atOff(wa, UNLOCK_ADDR_B))
                       ? ST_E3 : ST_IDLE;
      ST_E3:
        if (cmdWrite)
        begin
          state_next = ST_IDLE;
          if (wd == CMD_SECTOR_ERS || wd == CMD_BLOCK_ERS)
          begin
            startErase = 1'b1;
            state_next = ST_BUSY;
          end
          else if (wd == CMD_CHIP_ERS && atOff(wa, UNLOCK_ADDR_A)
                   && ppMode)
          begin
            startChip = 1'b1;
            state_next = ST_BUSY;
          end
        end
      ST_BUSY:
        if (opDone)
          state_next = ST_IDLE;
      ST_ABORT:
        if (rstN)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
    // Pin reset overrides any decode
    if (!rstN)
      state_next = (state_reg == ST_BUSY || state_reg == ST_ABORT)
                   ? ST_ABORT : ST_IDLE;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Operation kind, target and data capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_reg <= OP_NONE;
      target_byte_addr <= '0;
      sector_sel_addr <= '0;
      progData <= '0;
    end
    else if (startProg)
    begin
      op_reg <= OP_PROG;
      target_byte_addr <= wa[ADDR_W-1:0];
      progData <= wd;
    end
    else if (startErase)
    begin
      op_reg <= OP_ERASE;
      sector_sel_addr <= wa[ADDR_W-1:0];
    end
    else if (startChip)
      op_reg <= OP_CHIP;                     // address unused
    else if (state_reg != ST_BUSY)
      op_reg <= OP_NONE;
  end

  // Identification mode flag
  always_ff @(posedge clk)
  begin
    if (reset || !rstN)
      idMode <= 1'b0;
    else if (idEnter)
      idMode <= 1'b1;
    else if (idExit)
      idMode <= 1'b0;
  end

  // Cycles an operation survives a low reset pin; host hold time excluded
  always_ff @(posedge clk)
  begin
    if (reset || rstN || state_reg != ST_BUSY)
      abortCnt_reg <= '0;
    else
      abortCnt_reg <= abortCnt_reg + 1'b1;
  end

  // ----------------------------------------
  // Duration timer
  // ----------------------------------------
  logic [CNT_W-1:0] opLimit;
  logic             timerBusy;
  assign opLimit = startProg ? CNT_W'(PROG_LIMIT)
                 : startChip ? CNT_W'(CHIP_LIMIT)
                 : CNT_W'(ERASE_LIMIT);

  logic [CNT_W-1:0] limit_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
      limit_reg <= CNT_W'(PROG_LIMIT);
    else if (startProg || startErase || startChip)
      limit_reg <= opLimit;
  end

  fcs_op_timer #(.CW(CNT_W)) u_timer (
    .clk   (clk),
    .reset (reset),
    .start (startProg || startErase || startChip),
    .abort (!rstN),
    .limit ((startProg || startErase || startChip) ? opLimit
                                                   : limit_reg),
    .busy  (timerBusy),
    .done  (opDone)
  );

  // ----------------------------------------
  // Outputs and read path
  // ----------------------------------------
  logic toggle_reg;
  logic readLast_reg;

  // Status toggle flips once per read cycle while busy
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      toggle_reg <= 1'b0;
      readLast_reg <= 1'b0;
    end
    else
    begin
      readLast_reg <= readCycle;
      if (readCycle && !readLast_reg && state_reg == ST_BUSY)
        toggle_reg <= !toggle_reg;
    end
  end

  // Registered data pin drive
  always_ff @(posedge clk)
  begin
    if (reset || !rstN)
    begin
      dataOe <= 1'b0;
      dataOut <= '0;
    end
    else
    begin
      dataOe <= readCycle;
      if (state_reg == ST_BUSY)
        dataOut <= {(op_reg == OP_PROG) ? ~progData[7] : 1'b0,
                    toggle_reg, arrayData[5:0]};
      else if (idMode)
        dataOut <= wa[0] ? PART_CODE : MAKER_CODE;
      else
        dataOut <= arrayData;
    end
  end

  assign progStart  = startProg;
  assign eraseStart = startErase || startChip;
  assign chipErase  = startChip;
  assign opBusy     = (state_reg == ST_BUSY);
  assign readyIdle  = (state_reg == ST_IDLE) && !timerBusy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chip_mode_only_a: assert property (@(posedge clk) disable iff (reset)
    startChip |-> ppMode) else $error("chip erase outside parallel");
  reset_float_a: assert property (@(posedge clk) disable iff (reset)
    !rstN |=> !dataOe) else $error("data driven in reset");
  write_inhibit_a: assert property (@(posedge clk) disable iff (reset)
    (progStart || eraseStart) |-> oeN && weN) else $error("bad write");
  abort_time_a: assert property (@(posedge clk) disable iff (reset)
    abortCnt_reg <= CNT_W'(ABORT_CYCLES)) else $error("abort slow");
  erase_ignore_a: assert property (@(posedge clk) disable iff (reset)
    opBusy && !opDone && rstN |=> opBusy) else $error("busy left");
  back_idle_a: assert property (@(posedge clk) disable iff (reset)
    opDone && rstN |=> state_reg == ST_IDLE) else $error("no idle");
  id_enter_a: assert property (@(posedge clk) disable iff (reset)
    idEnter && rstN |=> idMode) else $error("id not entered");
  id_exit_a: assert property (@(posedge clk) disable iff (reset)
    idExit && rstN |=> !idMode) else $error("id not left");
  // Address stage reachable only through the unlock stages
  prog_cmd_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_PADDR |-> $past(state_reg) == ST_U2
                              || $past(state_reg) == ST_PADDR)
    else $error("program without unlock");
endmodule : fcs_sequencer

// file: verif/fcs_host.sv
`timescale 1ns/10ps
// Programmer model on the far side of the pins
module fcs_host
  import fcs_pkg::*;
(
  // Clock and read-back
  input  wire logic        clk,
  input  wire logic [7:0]  dataOut,
  input  wire logic        dataOe,
  // Pins toward the device
  output logic             rstPinN,
  output logic             outEnN,
  output logic             writeEnN,
  output logic [31:0]      addrIn,
  output logic [7:0]       dataIn
);
  // Pins idle, device reset held from time zero
  initial
  begin
    rstPinN  = 1'b0;
    outEnN   = 1'b1;
    writeEnN = 1'b1;
    addrIn   = 32'h0;
    dataIn   = 8'h0;
  end

  // Everything changes on falling edges only
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Power-up wait, then reset release and settle
  task automatic powerUp;
    tick(25000);
    rstPinN = 1'b1;
    tick(250);
  endtask : powerUp

  // One strobed write; slow high phase covers sync
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    addrIn   = a;
    dataIn   = d;
    writeEnN = 1'b0;
    tick(4);
    writeEnN = 1'b1;
    // Data held past the rise until the sync stage has taken it
    tick(2);
    // Released bus shows the inverse, not old data
    dataIn   = ~d;
    tick(4);
  endtask : wr

  // Unlock pair plus command, issued back to back
  task automatic unlock(input logic [7:0] cmd);
    wr({16'hffff, UNLOCK_ADDR_A}, UNLOCK_DATA_A);
    wr({16'hffff, UNLOCK_ADDR_B}, UNLOCK_DATA_B);
    wr({16'hffff, UNLOCK_ADDR_A}, cmd);
  endtask : unlock

  // One read cycle with output enable low
  task automatic rd(input logic [31:0] a, output logic [7:0] q,
                    output logic o);
    addrIn = a;
    outEnN = 1'b0;
    tick(6);
    q      = dataOut;
    o      = dataOe;
    outEnN = 1'b1;
    tick(4);
  endtask : rd

  // Reset pulse with output enable low meanwhile
  task automatic pinReset(output logic o);
    outEnN  = 1'b0;
    rstPinN = 1'b0;
    tick(25);
    o       = dataOe;
    outEnN  = 1'b1;
    rstPinN = 1'b1;
    tick(250);
  endtask : pinReset
endmodule : fcs_host

// file: verif/fcs_sequencer_tb_top.sv
`timescale 1ns/10ps
module fcs_sequencer_tb_top;
  import fcs_pkg::*;
  // --------------------------------------
  // Shortened operation times
  // --------------------------------------
  localparam int PL = 60;
  localparam int EL = 80;
  logic              clk;
  logic              reset;
  logic              parallel_prog_mode;
  wire logic         rstPinN, outEnN, writeEnN;
  wire logic [31:0]  addrIn;
  wire logic [7:0]   dataIn, arrayData, dataOut, progData;
  wire logic         dataOe, progStart, eraseStart, chipErase;
  wire logic [18:0]  target_byte_addr, sector_sel_addr;
  wire logic         opBusy, idMode, readyIdle;
  int                fails, n_checks, nProg, nErase, nChip;

  // Array contents follow the address
  assign arrayData = addrIn[7:0] ^ 8'h5a;

  fcs_sequencer #(.PROG_LIMIT(PL), .ERASE_LIMIT(EL), .CHIP_LIMIT(EL))
  fcs_sequencer_inst (.clk(clk), .reset(reset),
    .parallel_prog_mode(parallel_prog_mode), .rstPinN(rstPinN),
    .outEnN(outEnN), .writeEnN(writeEnN), .addrIn(addrIn),
    .dataIn(dataIn), .arrayData(arrayData), .dataOut(dataOut),
    .dataOe(dataOe), .progStart(progStart), .eraseStart(eraseStart),
    .chipErase(chipErase), .target_byte_addr(target_byte_addr),
    .sector_sel_addr(sector_sel_addr), .progData(progData),
    .opBusy(opBusy), .idMode(idMode), .readyIdle(readyIdle));

  fcs_host fcs_host_inst (.clk(clk), .dataOut(dataOut),
    .dataOe(dataOe), .rstPinN(rstPinN), .outEnN(outEnN),
    .writeEnN(writeEnN), .addrIn(addrIn), .dataIn(dataIn));

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Start pulses last one cycle; counted mid-cycle, where they are settled
  always @(negedge clk)
  begin
    if (progStart === 1'b1) nProg++;
    if (eraseStart === 1'b1) nErase++;
    if (chipErase === 1'b1) nChip++;
  end

  // --------------------------------------
  // Helpers
  // --------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for the operation to end
  task automatic waitIdle(output int n);
    n = 0;
    while (opBusy === 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : waitIdle

  task automatic give_verdict;
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Five erase unlock writes then the final one
  task automatic erase6(input logic [31:0] a, input logic [7:0] c);
    fcs_host_inst.unlock(CMD_ERASE_PRE);
    fcs_host_inst.wr(32'hffff_5555, UNLOCK_DATA_A);
    fcs_host_inst.wr(32'hffff_2aaa, UNLOCK_DATA_B);
    fcs_host_inst.wr(a, c);
  endtask : erase6

  // --------------------------------------
  // Scenarios
  // --------------------------------------
  task automatic t_prog;
    logic [7:0] q1, q2;
    logic       o;
    int         n;
    nProg = 0;
    fcs_host_inst.unlock(CMD_PROGRAM);
    fcs_host_inst.wr(32'hfff8_1234, 8'h4b);
    chk(nProg, 1);
    chk(target_byte_addr, 19'h01234);
    chk(progData, 8'h4b);
    fcs_host_inst.rd(32'hfff8_1234, q1, o);
    fcs_host_inst.rd(32'hfff8_1234, q2, o);
    chk(q1[7], 1'b1);
    chk(q1[6] ^ q2[6], 1'b1);
    waitIdle(n);
    chk(n < PL, 1'b1);
    chk(readyIdle, 1'b1);
  endtask : t_prog

  // Sector then block erase; commands during erase dropped
  task automatic t_erase;
    logic [7:0] q;
    logic       o;
    int         n;
    for (int i = 0; i < 2; i++)
    begin
      nErase = 0;
      nProg  = 0;
      erase6(32'hfff8_3000 + i * 32'h1_0000,
             i ? CMD_BLOCK_ERS : CMD_SECTOR_ERS);
      chk(nErase, 1);
      chk(sector_sel_addr, 19'h03000 + i * 19'h1_0000);
      fcs_host_inst.rd(32'hfff8_3000, q, o);
      chk(q[7], 1'b0);
      fcs_host_inst.unlock(CMD_PROGRAM);
      fcs_host_inst.wr(32'hfff8_0010, 8'h99);
      chk(nProg, 0);
      waitIdle(n);
      chk(n < EL, 1'b1);
      chk(readyIdle, 1'b1);
    end
  endtask : t_erase

  // Whole-array erase in parallel mode, refused otherwise
  task automatic t_chip;
    int n;
    for (int m = 1; m >= 0; m--)
    begin
      parallel_prog_mode = m[0];
      fcs_host_inst.tick(4);
      nChip = 0;
      erase6(32'hffff_5555, CMD_CHIP_ERS);
      chk(nChip, m);
      waitIdle(n);
      chk(readyIdle, 1'b1);
    end
    parallel_prog_mode = 1'b1;
    fcs_host_inst.tick(4);
  endtask : t_chip

  task automatic t_id;
    logic [7:0] q;
    logic       o;
    fcs_host_inst.unlock(CMD_ID_ENTRY);
    chk(idMode, 1'b1);
    fcs_host_inst.rd(32'hfff8_0000, q, o);
    chk(q, MAKER_CODE);
    fcs_host_inst.rd(32'hfff8_0001, q, o);
    chk(q, PART_CODE);
    fcs_host_inst.wr(32'h0003_1111, CMD_ID_EXIT);
    chk(idMode, 1'b0);
    fcs_host_inst.unlock(CMD_ID_ENTRY);
    fcs_host_inst.unlock(CMD_ID_EXIT);
    chk(idMode, 1'b0);
    fcs_host_inst.rd(32'hfff8_0001, q, o);
    chk(q, 8'h5b);
  endtask : t_id

  // Plain read, write inhibit, broken unlock sequence
  task automatic t_read;
    logic [7:0] q;
    logic       o;
    fcs_host_inst.rd(32'hfff8_00a5, q, o);
    chk(o, 1'b1);
    chk(q, 8'hff);
    nProg = 0;
    fcs_host_inst.outEnN = 1'b0;
    fcs_host_inst.unlock(CMD_PROGRAM);
    fcs_host_inst.wr(32'hfff8_0020, 8'h01);
    fcs_host_inst.outEnN = 1'b1;
    fcs_host_inst.tick(4);
    chk(nProg, 0);
    fcs_host_inst.wr(32'hffff_5555, UNLOCK_DATA_A);
    fcs_host_inst.wr(32'hffff_2aaa, UNLOCK_DATA_B);
    fcs_host_inst.wr(32'hffff_5555, 8'h77);
    fcs_host_inst.wr(32'hffff_5555, CMD_PROGRAM);
    fcs_host_inst.wr(32'hfff8_0020, 8'h02);
    chk(nProg, 0);
    chk(readyIdle, 1'b1);
  endtask : t_read

  // Reset in mid-program, then a full-length program
  task automatic t_abort;
    logic o;
    int   n;
    fcs_host_inst.unlock(CMD_PROGRAM);
    fcs_host_inst.wr(32'hfff8_0042, 8'h11);
    fcs_host_inst.tick(10);
    chk(opBusy, 1'b1);
    fcs_host_inst.rstPinN = 1'b0;
    fcs_host_inst.tick(8);
    chk(opBusy, 1'b0);
    fcs_host_inst.pinReset(o);
    chk(o, 1'b0);
    chk(opBusy, 1'b0);
    fcs_host_inst.unlock(CMD_PROGRAM);
    fcs_host_inst.wr(32'hfff8_0043, 8'h22);
    waitIdle(n);
    chk(n >= PL - 8 && n <= PL, 1'b1);
  endtask : t_abort

  // --------------------------------------
  // Main sequence and watchdog
  // --------------------------------------
  initial
  begin
    fails = 0;
    n_checks = 0;
    reset = 1'b1;
    parallel_prog_mode = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    fcs_host_inst.powerUp();
    chk(readyIdle, 1'b1);
    t_prog();
    t_erase();
    t_chip();
    t_id();
    t_read();
    t_abort();
    give_verdict();
  end

  // Tests need about 30000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : fcs_sequencer_tb_top
